// >>> host_bus_select_pkg.sv
// Shared types and constants for the storage card host bus front end
package host_bus_select_pkg;

  // ==========================================================================
  // Operating modes
  // ==========================================================================
  typedef enum logic [1:0] {
    MODE_MEMORY,
    MODE_IO,
    MODE_DISK
  } card_mode_e;

  // ==========================================================================
  // Widths and field positions
  // ==========================================================================
  localparam int unsigned DATA_W      = 16;
  localparam int unsigned BYTE_W      = 8;
  localparam int unsigned REG_SEL_W   = 3;   // Task file index width
  localparam int unsigned EVEN_LSB    = 0;   // Even byte starts on lane 0
  localparam int unsigned ODD_LSB     = 8;   // Odd byte starts on lane 8

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

  // Lane decode result carried from decode to the pins
  typedef struct packed {
    logic low_lane_en;   // Lanes 7:0 carry a byte
    logic high_lane_en;  // Lanes 15:8 carry a byte
    logic odd_to_low;    // Odd byte steered onto lanes 7:0
  } lane_sel_s;

  // Disk emulation register select
  typedef struct packed {
    logic                 task_file;  // First chip select range
    logic                 ctrl_block; // Alternate status / device control
    logic [REG_SEL_W-1:0] index;      // Register index
  } reg_sel_s;

endpackage

// >>> host_port_model.sv
// Host side model: card enables, strobes, address, cable select, DMA acknowledge
`timescale 1ns/1ns
`default_nettype none
module host_port_model
  import host_bus_select_pkg::*;
(
  input  wire logic            clk_sys,
  input  wire logic            rst_n,
  input  wire card_mode_e      card_mode,
  input  wire logic            dma_req,
  input  wire logic            dma_req_oe,
  output logic                 low_card_enable_n,
  output logic                 high_card_enable_n,
  output logic [REG_SEL_W-1:0] addr,
  output logic                 io_read_strobe_n,
  output logic                 io_write_strobe_n,
  output logic                 cable_select_n,
  output logic                 dma_ack_n,
  output logic [DATA_W-1:0]    data_in
);
  logic [7:0] pick;  // Random choices for this cycle
  logic       disk;  // Disk emulation mode
  assign disk = (card_mode == MODE_DISK);
  // ==========================================================
  // Idle bus at time zero
  initial begin
    {low_card_enable_n, high_card_enable_n, io_read_strobe_n} = 3'h7;
    {io_write_strobe_n, cable_select_n, dma_ack_n} = 3'h7;
    addr = 3'h0;
    data_in = 16'h0000;
  end
  // Host drives after the falling edge; data lines change every cycle when idle
  always @(negedge clk_sys) begin
    pick = 8'($urandom);
    data_in <= 16'($urandom);
    addr <= 3'($urandom);
    cable_select_n <= disk ? pick[7] : 1'b0;
    if (!rst_n) begin
      {low_card_enable_n, high_card_enable_n, io_read_strobe_n} <= 3'h7;
      {io_write_strobe_n, dma_ack_n} <= 2'h3;
    end else if (!dma_ack_n || (disk && dma_req && dma_req_oe && pick[2])) begin
      // Under acknowledge: selects negated, one strobe picks direction
      {low_card_enable_n, high_card_enable_n} <= 2'h3;
      io_read_strobe_n <= !(pick[0] & pick[1]);
      io_write_strobe_n <= !(pick[0] & !pick[1]);
      dma_ack_n <= !dma_ack_n && pick[3] && pick[4];
    end else begin
      // Disk mode never selects both ranges at once
      low_card_enable_n <= pick[0];
      high_card_enable_n <= pick[1] | (disk & !pick[0]);
      io_read_strobe_n <= pick[5];
      io_write_strobe_n <= !pick[5] | pick[6];
      dma_ack_n <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> storage_card_host_bus_select.sv
// Host bus front end: lane steering, register select, role, acknowledge, DMA
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - In card modes high enable alone routes the odd byte
// - Eight-bit hosts reach all bytes on low lanes
// - First select is task file, second control
// - During DMA acknowledge: no selects, words only
// - Cable select pulled high; grounded means master
// - Even byte on lane 0, odd on 8
// - Task file bytes low lanes, data words
// - Acknowledge asserted on selected I/O reads
// - Acknowledge unused in memory mode
// - Request only when ready to move data
// - Strobe chooses DMA direction; device follows
// - Hold request until acknowledge, reassert if more
// - Request undriven when device not selected
// - Only address bits 2:0 pick register
module storage_card_host_bus_select
  import host_bus_select_pkg::*;
(
  input  wire logic              clk_sys,               // 250 MHz system clock
  input  wire logic              rst_n,                 // Synchronous reset
  input  wire card_mode_e        card_mode,             // Mode chosen at power up
  input  wire logic              low_card_enable_n,     // Low card enable / first select
  input  wire logic              high_card_enable_n,    // High card enable / second select
  input  wire logic [REG_SEL_W-1:0] addr,               // Address bits 2:0
  input  wire logic              io_read_strobe_n,      // I/O read strobe
  input  wire logic              io_write_strobe_n,     // I/O write strobe
  input  wire logic              cable_select_n,        // Pulled high on card
  input  wire logic              dma_ack_n,             // DMA acknowledge from host
  input  wire logic              dev_selected,          // Drive select matches our role
  input  wire logic              xfer_ready,            // Back end ready to move a word
  input  wire logic              xfer_more,             // More words remain
  input  wire logic [DATA_W-1:0] read_word,             // Word from the back end
  input  wire logic [DATA_W-1:0] data_in,               // Data pins, input side
  output logic [DATA_W-1:0]      data_out,              // Data pins, output side
  output logic [1:0]             data_oe,               // Per-byte lane drive enables
  output logic [DATA_W-1:0]      write_word,            // Word toward the back end
  output lane_sel_s              lane_sel,              // Registered lane decode
  output reg_sel_s               reg_sel,               // Registered register select
  output logic                   is_master,             // Role in disk emulation
  output logic                   io_read_acknowledge_n, // Acknowledge pin
  output logic                   dma_req,               // DMA request level
  output logic                   dma_req_oe,            // DMA request drive enable
  output logic                   dma_dir_read,          // Last DMA strobe was a read
  output logic                   dma_protocol_err       // Select seen during DMA ack
);

  // ==========================================================================
  // Decode functions
  // ==========================================================================
  // Lane decode shared by read drive and write capture
  function automatic lane_sel_s lane_decode(input logic ce_lo_n, input logic ce_hi_n,
                                            input logic a0);
    lane_sel_s s;
    s = '0;
    if (!ce_lo_n && !ce_hi_n) begin
      s.low_lane_en  = 1'b1;   // Word access
      s.high_lane_en = 1'b1;
    end else if (!ce_hi_n) begin
      s.high_lane_en = 1'b1;   // Odd byte on its own lanes
    end else if (!ce_lo_n) begin
      s.low_lane_en  = 1'b1;
      s.odd_to_low   = a0;     // Byte host picks odd byte by address
    end
    return s;
  endfunction

  // ==========================================================================
  // Combinational decode
  // ==========================================================================
  logic      disk_mode;     // Disk emulation active
  logic      dma_active;    // Host acknowledges DMA
  logic      any_strobe;    // A read or write strobe is low
  logic      io_mode;       // PC card I/O mode active
  lane_sel_s lane_d;        // Next lane selection
  reg_sel_s  reg_d;         // Next register select

  assign disk_mode  = (card_mode == MODE_DISK);
  assign dma_active = disk_mode && !dma_ack_n;
  assign any_strobe = !io_read_strobe_n || !io_write_strobe_n;
  // Acknowledge is gated by this, the read strobe and the selects, so memory mode can never raise it
  assign io_mode    = (card_mode == MODE_IO);

  // Lane selection per mode
  always_comb begin
    lane_d = '0;
    reg_d  = '0;
    if (dma_active) begin
      lane_d.low_lane_en  = 1'b1;
      lane_d.high_lane_en = 1'b1;
    end else if (disk_mode) begin
      reg_d.task_file  = !low_card_enable_n;
      reg_d.ctrl_block = !high_card_enable_n;
      reg_d.index      = addr;
      // Register accesses are bytes on low lanes only
      lane_d.low_lane_en = reg_d.task_file || reg_d.ctrl_block;
    end else begin
      lane_d = lane_decode(low_card_enable_n, high_card_enable_n, addr[0]);
    end
  end

  // Read data steering; odd byte moved down for byte hosts
  logic [DATA_W-1:0] drive_d;
  always_comb begin
    drive_d = read_word;
    if (lane_d.odd_to_low) begin
      drive_d[EVEN_LSB +: BYTE_W] = read_word[ODD_LSB +: BYTE_W];
    end
  end

  // ==========================================================================
  // Data lanes
  // ==========================================================================
  // Drive only while the host strobes a read, so writes never fight the host
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      data_out <= DATA_RST;
      data_oe  <= 2'h0;
    end else begin
      data_out <= drive_d;
      data_oe  <= (!io_read_strobe_n) ? {lane_d.high_lane_en, lane_d.low_lane_en} : 2'h0;
    end
  end

  // Write capture; byte host odd data arrives on low lanes
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      write_word <= DATA_RST;
    end else if (!io_write_strobe_n) begin
      write_word <= data_in;
      if (lane_d.odd_to_low) begin
        write_word[ODD_LSB +: BYTE_W] <= data_in[EVEN_LSB +: BYTE_W];
      end
    end
  end

  // Decode results registered for the back end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      lane_sel <= '0;
      reg_sel  <= '0;
    end else begin
      lane_sel <= lane_d;
      reg_sel  <= reg_d;
    end
  end

  // ==========================================================================
  // Role from cable select
  // ==========================================================================
  // Pin reads high when open due to the on-card pull up; card modes ignore it
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      is_master <= 1'b0;
    end else begin
      is_master <= disk_mode && !cable_select_n;
    end
  end

  // ==========================================================================
  // Input acknowledge
  // ==========================================================================
  // Only in I/O mode; memory and disk modes keep it negated
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      io_read_acknowledge_n <= 1'b1;
    end else begin
      io_read_acknowledge_n <= !(io_mode && !io_read_strobe_n &&
                                 (!low_card_enable_n || !high_card_enable_n));
    end
  end

  // ==========================================================================
  // DMA request handshake
  // ==========================================================================
  // Request rises when ready; falls once acknowledged with no words left, or on deselect
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dma_req <= 1'b0;
    end else if (!disk_mode || !dev_selected) begin
      dma_req <= 1'b0;
    end else if (dma_req) begin
      if (dma_active && !xfer_more) begin
        dma_req <= 1'b0;
      end
    end else if (xfer_ready && xfer_more && dma_ack_n) begin
      dma_req <= 1'b1;
    end
  end

  // Not driven when another device owns the bus
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dma_req_oe <= 1'b0;
    end else begin
      dma_req_oe <= disk_mode && dev_selected;
    end
  end

  // Direction follows whichever strobe the host pulses
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dma_dir_read <= 1'b0;
    end else if (dma_active && any_strobe) begin
      dma_dir_read <= !io_read_strobe_n;
    end
  end

  // Sticky flag when the host breaks the select-negated contract
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dma_protocol_err <= 1'b0;
    end else if (dma_active && (!low_card_enable_n || !high_card_enable_n)) begin
      dma_protocol_err <= 1'b1;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_ack_memory_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (card_mode == MODE_MEMORY) |=> io_read_acknowledge_n)
    else $error("acknowledge asserted in memory mode");

  a_ack_io_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (card_mode == MODE_IO && !io_read_strobe_n && !low_card_enable_n)
      |=> !io_read_acknowledge_n)
    else $error("acknowledge missing on selected read");

  a_ack_no_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    io_read_strobe_n |=> io_read_acknowledge_n)
    else $error("acknowledge asserted without read");

  a_req_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (dma_req && dma_ack_n && disk_mode && dev_selected) |=> dma_req)
    else $error("request dropped before acknowledge");

  a_req_undriven: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !dev_selected |=> !dma_req_oe)
    else $error("request driven while unselected");

  a_req_ready: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(dma_req) |-> $past(xfer_ready))
    else $error("request raised while not ready");

  a_dma_word: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (dma_active && !io_read_strobe_n) |=> (data_oe == 2'h3))
    else $error("DMA read not a full word");

  a_task_low_lane: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (disk_mode && dma_ack_n) |=> !lane_sel.high_lane_en)
    else $error("task file access used high lanes");

  a_odd_byte_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!disk_mode && !low_card_enable_n && high_card_enable_n && addr[0])
      |=> (data_out[EVEN_LSB +: BYTE_W] == $past(read_word[ODD_LSB +: BYTE_W])))
    else $error("odd byte not steered to low lanes");

  a_master_role: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (disk_mode && !cable_select_n) |=> is_master)
    else $error("grounded cable select not master");

endmodule
`default_nettype wire

// >>> test_storage_card_host_bus_select.sv
// Testbench: random host traffic per mode, compared with a reference model
`timescale 1ns/1ns
`default_nettype none
module test_storage_card_host_bus_select;
  import host_bus_select_pkg::*;
  // ==========================================================
  // Signals
  logic clk_sys = 0, rst_n = 0, dev_selected = 1, xfer_ready = 0, xfer_more = 0;
  card_mode_e  card_mode = MODE_MEMORY;
  logic [15:0] read_word = 16'h0000, data_in, data_out, write_word;
  logic [2:0]  addr;
  logic [1:0]  data_oe;
  lane_sel_s   lane_sel;
  reg_sel_s    reg_sel;
  logic lo_n, hi_n, rd_n, wr_n, cs_n, ack_n, is_master, inp_ack_n;
  logic dma_req, dma_req_oe, dma_dir_read, dma_protocol_err;
  int   err_count = 0, n_tests = 0;
  // Snapshot of inputs at the sampling edge, and model state
  logic s_rst, s_lo, s_hi, s_rd, s_wr, s_cs, s_ack, s_sel, s_rdy, s_more, req_m;
  logic disk, rd;
  logic [2:0]  s_a;
  logic [15:0] s_rw, s_din, ww_m;  // ww_m: expected captured write word
  card_mode_e  s_mode;
  always #2 clk_sys = ~clk_sys;
  storage_card_host_bus_select storage_card_host_bus_select_i (.clk_sys(clk_sys),
    .rst_n(rst_n), .card_mode(card_mode), .low_card_enable_n(lo_n),
    .high_card_enable_n(hi_n), .addr(addr), .io_read_strobe_n(rd_n),
    .io_write_strobe_n(wr_n), .cable_select_n(cs_n), .dma_ack_n(ack_n),
    .dev_selected(dev_selected), .xfer_ready(xfer_ready), .xfer_more(xfer_more),
    .read_word(read_word), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .write_word(write_word), .lane_sel(lane_sel), .reg_sel(reg_sel),
    .is_master(is_master), .io_read_acknowledge_n(inp_ack_n), .dma_req(dma_req),
    .dma_req_oe(dma_req_oe), .dma_dir_read(dma_dir_read),
    .dma_protocol_err(dma_protocol_err));
  host_port_model host_port_model_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .card_mode(card_mode), .dma_req(dma_req), .dma_req_oe(dma_req_oe),
    .low_card_enable_n(lo_n), .high_card_enable_n(hi_n), .addr(addr),
    .io_read_strobe_n(rd_n), .io_write_strobe_n(wr_n), .cable_select_n(cs_n),
    .dma_ack_n(ack_n), .data_in(data_in));
  // ==========================================================
  // Compare one value, count it, report a difference at once
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Reference model: every output answers the inputs of the previous edge
  always @(posedge clk_sys) begin
    {s_rst, s_lo, s_hi, s_rd, s_wr, s_cs, s_ack} = {rst_n, lo_n, hi_n, rd_n, wr_n, cs_n, ack_n};
    {s_sel, s_rdy, s_more, s_a, s_rw, s_din} = {dev_selected, xfer_ready, xfer_more, addr,
      read_word, data_in};
    s_mode = card_mode;
    #1;
    disk = (s_mode == MODE_DISK);
    rd = (s_mode == MODE_IO) && !(s_lo && s_hi) && !s_rd;
    if (!s_rst) begin
      req_m = 1'b0;
      ww_m = 16'h0000;
      check({inp_ack_n, data_oe, dma_req, dma_req_oe, is_master}, 16'h0020);
    end else begin
      check(inp_ack_n, !rd);
      check(is_master, disk && !s_cs);
      check(dma_protocol_err, 0);
      // Card modes: lanes driven only under the read strobe
      if (!disk) check(data_oe, s_rd ? 2'h0 : {!s_hi, !s_lo});
      if (!disk && !s_lo)
        check(data_out[7:0], (s_hi & s_a[0]) ? s_rw[15:8] : s_rw[7:0]);
      if (!disk && !s_hi) check(data_out[15:8], s_rw[15:8]);
      if (disk) check(data_out, s_rw);
      if (!disk) check(lane_sel, {!s_lo, !s_hi, !s_lo && s_hi && s_a[0]});
      else check(lane_sel, !s_ack ? 3'h6 : {!(s_lo && s_hi), 2'h0});
      // Byte host odd write arrives on the low lanes and lands in the high byte
      if (!s_wr) ww_m = (!disk && !s_lo && s_hi && s_a[0]) ? {2{s_din[7:0]}} : s_din;
      check(write_word, ww_m);
      check(reg_sel, (disk && s_ack) ? {!s_lo, !s_hi, s_a} : 5'h00);
      if (disk && s_ack && (s_lo ^ s_hi) && !s_rd) check(data_oe, 2'h1);
      if (disk && !s_ack && !s_rd) check({data_oe, dma_dir_read}, 3'h7);
      if (disk && !s_ack && !s_wr) check(dma_dir_read, 0);
      // Request held until acknowledged with nothing left, raised only when ready
      if (!disk || !s_sel) req_m = 1'b0;
      else if (req_m) req_m = s_ack || s_more;
      else req_m = s_ack && s_rdy && s_more;
      check(dma_req, req_m);
      check(dma_req_oe, disk && s_sel);
    end
  end
  // ==========================================================
  // Main sequence: each mode after its own reset, back end randomised
  initial begin
    void'($urandom(32'h55EF));
    for (int m = 0; m < 3; m++) begin
      // Reset spans exactly three rising edges, at start and per mode
      rst_n = 0;
      card_mode = card_mode_e'(m);
      repeat (3) @(negedge clk_sys);
      rst_n = 1;
      repeat (3000) begin
        @(negedge clk_sys);
        dev_selected = ($urandom % 8) != 0;
        {xfer_ready, xfer_more} = 2'($urandom);
        read_word = 16'($urandom);
      end
    end
    final_report();
  end
  // Watchdog well beyond the planned run of about 9000 cycles
  initial begin
    #60000;
    err_count++;
    final_report();
  end
endmodule
`default_nettype wire
